// ===== caption_remote_inputs.sv
// Remote contact inputs, keyer, bypass, port disable, row shift, stream monitor
//
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/1ns

// Operation
// - Inputs read as one eight-bit byte
// - Fixed bit map of ports, keyer, shift, bypass
// - Master mode: keyer follows disable input level
// - Temporary mode: stay off until serial byte
// - Config switch picks mode, master by default
// - Bypass input low routes video to bypass
// - Port disable low resets and gates port
// - Shift low moves rows 12-15 to 1-4
// - Shift only touches position codes sent after
// - Monitor also reports three logic revisions
// - Packets kept nonvolatile, erased by command only
// - Local erase clears packets, keeps articles
// - Factory restore: defaults, buffers, queues, stores
// - Power-on reset reloads settings, clears queues
// - Status for nine streams C1-4 T1-4 E
// - Indicator shows presence or block
// - Regenerate re-encodes, direct wire copies
// - Direct or real-time uses serial data
// - Article state uses article queue
module caption_remote_inputs
   import remote_inputs_pkg::*;
#(
   parameter int                   DEBOUNCE_CYCLES = DEBOUNCE_CYC,
   parameter logic [7:0]           REV_A           = 8'h11,
   parameter logic [7:0]           REV_B           = 8'h22,
   parameter logic [7:0]           REV_C           = 8'h33
) (
   // Clock and reset
   input  wire logic               sys_clk,
   input  wire logic               rstn,
   // APB slave
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [11:0]        paddr,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   // Contact closure inputs
   input  wire logic [7:0]         gpi_n,
   // Serial port activity
   input  wire logic [2:0]         port_byte_rx,
   output logic      [2:0]         port_reset,
   output logic      [2:0]         port_enable,
   // Keyer and bypass
   output logic                    keyer_on,
   output logic                    bypass_on,
   // Caption data path
   input  cc_pair_t                cc_in,
   output cc_pair_t                cc_out,
   // Stream sources
   input  wire logic [N_STREAMS-1:0] upstream_present,
   output logic      [N_STREAMS-1:0] src_regen,
   output logic      [N_STREAMS-1:0] src_wire,
   output logic      [N_STREAMS-1:0] src_serial,
   output logic      [N_STREAMS-1:0] src_article,
   // Packet store actions
   output store_act_t              store_act
);

   logic [7:0]            sync1;
   logic [7:0]            sync2;
   logic [7:0]            gpi;
   logic [7:0]            gpi_prev;
   logic [7:0][15:0]      bounce_cnt;
   logic                  temp_mode;
   logic                  keyer_hold;
   logic                  shift_on;
   logic [3*N_STREAMS-1:0] stream_mode;
   logic [N_STREAMS-1:0]  stream_mask;
   logic                  apb_wr;
   logic                  apb_rd;
   logic [31:0]           next_rdata;
   logic [2:0]            act_pulse;
   logic [3:0]            shift_code;

   // SCREEN_POSITION_CODE first byte 0x10-0x17 with second byte 0x40-0x7F
   function automatic logic is_pac(input logic [6:0] b1, input logic [6:0] b2);
      return (b1[6:3] == 4'h2) && b2[6];
   endfunction

   // Row number from SCREEN_POSITION_CODE bytes, 1..15
   function automatic logic [3:0] pac_row(input logic [6:0] b1, input logic [6:0] b2);
      logic [3:0] row;
      row = 4'h0;
      case ({b1[2:0], b2[5]})
         4'h2:    row = 4'h1;
         4'h3:    row = 4'h2;
         4'h4:    row = 4'h3;
         4'h5:    row = 4'h4;
         4'hA:    row = 4'h5;
         4'hB:    row = 4'h6;
         4'hC:    row = 4'h7;
         4'hD:    row = 4'h8;
         4'hE:    row = 4'h9;
         4'hF:    row = 4'hA;
         4'h0:    row = 4'hB;
         4'h6:    row = 4'hC;
         4'h7:    row = 4'hD;
         4'h8:    row = 4'hE;
         4'h9:    row = 4'hF;
         default: row = 4'h0;
      endcase
      return row;
   endfunction

   // Rebuild SCREEN_POSITION_CODE first byte and row bit for rows 1..4
   function automatic logic [3:0] pac_code(input logic [3:0] row);
      logic [3:0] code;
      code = 4'h2;
      case (row)
         4'h1:    code = 4'h2;
         4'h2:    code = 4'h3;
         4'h3:    code = 4'h4;
         default: code = 4'h5;
      endcase
      return code;
   endfunction

   // Stream mode field of one stream
   function automatic stream_mode_t mode_of(input logic [3*N_STREAMS-1:0] m, input int i);
      return stream_mode_t'(m[3*i +: 3]);
   endfunction

   // Input synchroniser, two flops
   // two-flop sync
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         sync1 <= 8'hFF;
         sync2 <= 8'hFF;
      end else begin
         sync1 <= gpi_n;
         sync2 <= sync1;
      end
   end

   // Debounce: level must stand a full window before it is taken
   // debounce per input
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         gpi        <= 8'hFF;
         bounce_cnt <= '0;
      end else begin
         for (int i = 0; i < 8; i++) begin
            if (sync2[i] == gpi[i]) begin
               bounce_cnt[i] <= 16'h0000;
            end else if (bounce_cnt[i] >= 16'(DEBOUNCE_CYCLES - 1)) begin
               gpi[i]        <= sync2[i];
               bounce_cnt[i] <= 16'h0000;
            end else begin
               bounce_cnt[i] <= bounce_cnt[i] + 16'h0001;
            end
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         gpi_prev <= 8'hFF;
      end else begin
         gpi_prev <= gpi;
      end
   end

   // Port disable: one reset pulse on falling edge, gate while low
   // port reset gating
   always_comb begin
      port_reset[0]  = gpi_prev[BIT_PORT_A_DIS] & ~gpi[BIT_PORT_A_DIS];
      port_reset[1]  = gpi_prev[BIT_PORT_B_DIS] & ~gpi[BIT_PORT_B_DIS];
      port_reset[2]  = gpi_prev[BIT_PORT_C_DIS] & ~gpi[BIT_PORT_C_DIS];
      port_enable[0] = gpi[BIT_PORT_A_DIS];
      port_enable[1] = gpi[BIT_PORT_B_DIS];
      port_enable[2] = gpi[BIT_PORT_C_DIS];
   end

   // Temporary mode hold; a byte on a gated port does not count
   // temporary keyer hold
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         keyer_hold <= 1'b0;
      end else if (!gpi[BIT_KEYER_DIS]) begin
         keyer_hold <= 1'b1;
      end else if (|(port_byte_rx & port_enable)) begin
         keyer_hold <= 1'b0;
      end
   end

   always_comb begin
      if (temp_mode) begin
         keyer_on = gpi[BIT_KEYER_DIS] & ~keyer_hold;
      end else begin
         keyer_on = gpi[BIT_KEYER_DIS];
      end
   end

   assign bypass_on = ~gpi[BIT_BYPASS_EN];

   // Target code for a row moved up by the shift
   // shifted row code
   always_comb begin
      shift_code = pac_code(pac_row(cc_in.b1, cc_in.b2) - ROW_SHIFT_BY);
   end

   // Row shift, applied only to codes that follow the shift
   // SCREEN_POSITION_CODE row shift
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         cc_out   <= '0;
         shift_on <= 1'b0;
      end else begin
         shift_on <= ~gpi[BIT_SHIFT_UP];
         cc_out   <= cc_in;
         if (cc_in.valid && shift_on && is_pac(cc_in.b1, cc_in.b2) &&
             pac_row(cc_in.b1, cc_in.b2) >= ROW_SHIFT_LO &&
             pac_row(cc_in.b1, cc_in.b2) <= ROW_SHIFT_HI) begin
            cc_out.b1[2:0] <= shift_code[3:1];
            cc_out.b2[5]   <= shift_code[0];
         end
      end
   end

   // Stream source selection
   // source select
   always_comb begin
      for (int i = 0; i < N_STREAMS; i++) begin
         src_regen[i]   = mode_of(stream_mode, i) == MODE_REGEN;
         src_wire[i]    = mode_of(stream_mode, i) == MODE_DIRECT_WIRE;
         src_serial[i]  = mode_of(stream_mode, i) == MODE_DIRECT_CTRL ||
                          mode_of(stream_mode, i) == MODE_REAL_TIME;
         src_article[i] = mode_of(stream_mode, i) == MODE_ARTICLE;
      end
   end

   // APB decode; single-cycle answer
   assign pready  = 1'b1;
   assign apb_wr  = psel & penable & pwrite;
   assign apb_rd  = psel & ~pwrite;
   assign pslverr = 1'b0;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         temp_mode   <= CTRL_RESET[CTRL_TEMP_MODE];
         stream_mode <= '0;
         stream_mask <= '0;
         act_pulse   <= 3'b000;
      end else begin
         act_pulse <= 3'b000;
         if (apb_wr && paddr == OFF_CTRL) begin
            temp_mode <= pwdata[CTRL_TEMP_MODE];
         end else if (apb_wr && paddr == OFF_STREAM_MD) begin
            stream_mode <= pwdata[3*N_STREAMS-1:0];
         end else if (apb_wr && paddr == OFF_ACTION) begin
            act_pulse <= pwdata[2:0];
         end
         // Factory restore and power-on reset reload temp_mode from CTRL_RESET
         if (act_pulse[ACT_FACTORY] || act_pulse[ACT_POWER_ON]) begin
            temp_mode <= CTRL_RESET[CTRL_TEMP_MODE];
         end
         stream_mask <= upstream_present;
      end
   end

   // Store actions from one write to the action register
   // store actions
   always_comb begin
      store_act.erase_packets      = act_pulse[ACT_ERASE_PKT] | act_pulse[ACT_FACTORY];
      store_act.delete_articles    = act_pulse[ACT_FACTORY];
      store_act.clear_queues       = act_pulse[ACT_FACTORY] | act_pulse[ACT_POWER_ON];
      store_act.clear_port_buffers = act_pulse[ACT_FACTORY];
      store_act.load_defaults      = act_pulse[ACT_FACTORY];
      store_act.reload_nv          = act_pulse[ACT_POWER_ON];
   end

   // Read mux; indicator: present beats mode code, block beats both
   // readback
   always_comb begin
      next_rdata = 32'h0000_0000;
      if (paddr == OFF_GPI_MON) begin
         // Debounced level, so a chattering contact reads steady
         next_rdata = {24'h000000, gpi};
      end else if (paddr == OFF_REV) begin
         next_rdata = {8'h00, REV_A, REV_B, REV_C};
      end else if (paddr == OFF_CTRL) begin
         next_rdata = {31'h0, temp_mode};
      end else if (paddr == OFF_STATUS) begin
         next_rdata = {27'h0, keyer_hold, bypass_on, keyer_on, shift_on, 1'b0};
      end else if (paddr == OFF_STREAM_MD) begin
         next_rdata = {5'h00, stream_mode};
      end else if (paddr == OFF_STREAM_IN) begin
         for (int i = 0; i < N_STREAMS; i++) begin
            if (mode_of(stream_mode, i) == MODE_BLOCK) begin
               next_rdata[3*i +: 3] = IND_BLOCK;
            end else if (stream_mask[i]) begin
               next_rdata[3*i +: 3] = IND_PRESENT;
            end else begin
               case (mode_of(stream_mode, i))
                  MODE_DIRECT_CTRL: next_rdata[3*i +: 3] = IND_DIRECT;
                  MODE_REAL_TIME:   next_rdata[3*i +: 3] = IND_REAL_TIME;
                  MODE_ARTICLE:     next_rdata[3*i +: 3] = IND_ARTICLE;
                  MODE_DIRECT_WIRE: next_rdata[3*i +: 3] = IND_WIRE;
                  default:          next_rdata[3*i +: 3] = IND_REGEN;
               endcase
            end
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         prdata <= 32'h0000_0000;
      end else if (apb_rd && !penable) begin
         prdata <= next_rdata;
      end
   end

   // Assertions
   a_bypass_level: assert property (@(posedge sys_clk) disable iff (!rstn)
      bypass_on == !gpi[BIT_BYPASS_EN]) else $error("bypass not tracking input");
   a_master_keyer: assert property (@(posedge sys_clk) disable iff (!rstn)
      !temp_mode |-> keyer_on == gpi[BIT_KEYER_DIS]) else $error("master keyer wrong");
   a_temp_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
      temp_mode && !gpi[BIT_KEYER_DIS] ##1 gpi[BIT_KEYER_DIS] && !(|port_byte_rx)
      |-> !keyer_on) else $error("temporary keyer released early");
   a_port_reset_once: assert property (@(posedge sys_clk) disable iff (!rstn)
      port_reset[0] |=> !port_reset[0] && !port_enable[0]) else $error("port reset repeat");
   a_port_gate: assert property (@(posedge sys_clk) disable iff (!rstn)
      $fell(gpi[BIT_PORT_B_DIS]) |-> port_reset[1] && !port_enable[1])
      else $error("port B not reset");
   a_erase_keeps: assert property (@(posedge sys_clk) disable iff (!rstn)
      act_pulse == 3'b001 |-> store_act.erase_packets && !store_act.delete_articles)
      else $error("erase touched articles");
   a_factory_all: assert property (@(posedge sys_clk) disable iff (!rstn)
      act_pulse[ACT_FACTORY] |-> store_act.load_defaults && store_act.clear_queues &&
      store_act.clear_port_buffers && store_act.erase_packets) else $error("factory partial");
   a_power_keeps: assert property (@(posedge sys_clk) disable iff (!rstn)
      act_pulse == 3'b100 |-> store_act.clear_queues && !store_act.erase_packets)
      else $error("power-on erased store");
   a_debounce_hold: assert property (@(posedge sys_clk) disable iff (!rstn)
      $changed(gpi[0]) |-> $past(sync2[0]) == gpi[0]) else $error("debounce took bounce");

   a_debounce_window: assert property (@(posedge sys_clk) disable iff (!rstn)
      $changed(gpi[1]) |-> $past(bounce_cnt[1]) >= 16'(DEBOUNCE_CYCLES - 1))
      else $error("keyer input taken before window");

   a_shift_row_up: assert property (@(posedge sys_clk) disable iff (!rstn)
      cc_in.valid && shift_on && cc_in.b1 == 7'h13 && cc_in.b2[6:5] == 2'b10
      |=> cc_out.b1 == 7'h11 && !cc_out.b2[5]) else $error("row 12 not moved to row 1");

   a_shift_off_pass: assert property (@(posedge sys_clk) disable iff (!rstn)
      !shift_on |=> cc_out == $past(cc_in)) else $error("caption altered without shift");

   a_keyer_hold_set: assert property (@(posedge sys_clk) disable iff (!rstn)
      !gpi[BIT_KEYER_DIS] |=> keyer_hold) else $error("keyer hold not set");

   a_block_no_src: assert property (@(posedge sys_clk) disable iff (!rstn)
      mode_of(stream_mode, 0) == MODE_BLOCK |-> !src_regen[0] && !src_wire[0] &&
      !src_serial[0] && !src_article[0]) else $error("blocked stream still sourced");

endmodule

// ===== remote_inputs_pkg.sv
// Package of constants and carriers for the remote input block
package remote_inputs_pkg;

   // Input bit positions
   localparam int BIT_PORT_A_DIS = 0;
   localparam int BIT_KEYER_DIS  = 1;
   localparam int BIT_PORT_B_DIS = 2;
   localparam int BIT_SHIFT_UP   = 3;
   localparam int BIT_PORT_C_DIS = 4;
   localparam int BIT_UNUSED     = 6;
   localparam int BIT_BYPASS_EN  = 7;

   // Register offsets
   localparam logic [11:0] OFF_GPI_MON   = 12'h000;
   localparam logic [11:0] OFF_REV       = 12'h004;
   localparam logic [11:0] OFF_CTRL      = 12'h008;
   localparam logic [11:0] OFF_STATUS    = 12'h00C;
   localparam logic [11:0] OFF_STREAM_MD = 12'h010;
   localparam logic [11:0] OFF_STREAM_IN = 12'h014;
   localparam logic [11:0] OFF_ACTION    = 12'h018;

   // Control field positions and reset values
   localparam int CTRL_TEMP_MODE = 0;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam int ACT_ERASE_PKT  = 0;
   localparam int ACT_FACTORY    = 1;
   localparam int ACT_POWER_ON   = 2;

   // Debounce time and cycles at 20 MHz
   localparam int CLK_HZ       = 20_000_000;
   localparam int DEBOUNCE_US  = 2000;
   localparam int DEBOUNCE_CYC = DEBOUNCE_US * (CLK_HZ / 1_000_000);

   // Row shift limits
   localparam logic [3:0] ROW_SHIFT_LO = 4'hC;
   localparam logic [3:0] ROW_SHIFT_HI = 4'hF;
   localparam logic [3:0] ROW_SHIFT_BY = 4'hB;

   localparam int N_STREAMS = 9;

   // Per-stream processing modes
   typedef enum logic [2:0] {
      MODE_REGEN,
      MODE_BLOCK,
      MODE_DIRECT_WIRE,
      MODE_DIRECT_CTRL,
      MODE_REAL_TIME,
      MODE_ARTICLE
   } stream_mode_t;

   // Stream indicator codes shown on the monitor
   typedef enum logic [2:0] {
      IND_REGEN,
      IND_BLOCK,
      IND_PRESENT,
      IND_DIRECT,
      IND_REAL_TIME,
      IND_ARTICLE,
      IND_WIRE
   } indicator_t;

   // Store action pulses
   typedef struct packed {
      logic erase_packets;
      logic delete_articles;
      logic clear_queues;
      logic clear_port_buffers;
      logic load_defaults;
      logic reload_nv;
   } store_act_t;

   // Caption byte pair on the data path
   typedef struct packed {
      logic       valid;
      logic [6:0] b1;
      logic [6:0] b2;
   } cc_pair_t;

endpackage

// ===== remote_contacts.sv
// Contact closure model for the remote control connector
`timescale 1ns/1ns
module remote_contacts (
   // Clock
   input  wire logic       sys_clk,
   // Contact lines, pulled up while open
   output logic      [7:0] gpi_n
);
   initial gpi_n = 8'hFF;

   // Real contacts chatter; each bounce lasts one cycle, shorter than the window
   task automatic set_line(input int b, input logic closed, input int bounces);
      for (int k = 0; k < bounces; k++) begin
         @(posedge sys_clk);
         gpi_n[b] <= (k % 2 == 0) ? ~closed : closed;
      end
      @(posedge sys_clk);
      gpi_n[b] <= ~closed;
   endtask

   // Whole word at once, no bounce
   task automatic set_word(input logic [7:0] v);
      @(posedge sys_clk);
      gpi_n <= v;
   endtask
endmodule

// ===== tb_top.sv
// Self-checking testbench for the remote input block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
   $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module tb_top
   import remote_inputs_pkg::*;
;
   localparam int D = 4;
   // Arbitrary revision values
   localparam logic [7:0] RA = 8'h5A, RB = 8'h3C, RC = 8'h96;
   logic sys_clk, rstn, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q, seed;
   logic [7:0] gpi_n, v;
   logic [2:0] port_byte_rx, port_reset, port_enable;
   logic keyer_on, bypass_on, clr_seen;
   cc_pair_t cc_in, cc_out;
   logic [N_STREAMS-1:0] upstream_present, src_regen, src_wire, src_serial, src_article;
   store_act_t store_act, seen;
   logic [5:0] ex [3], mk [3];
   logic [26:0] md;
   int n_fail = 0, tests_run = 0, rst_cnt [3];

   caption_remote_inputs #(.DEBOUNCE_CYCLES(D), .REV_A(RA), .REV_B(RB), .REV_C(RC))
      i_caption_remote_inputs (.sys_clk(sys_clk), .rstn(rstn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .gpi_n(gpi_n),
      .port_byte_rx(port_byte_rx), .port_reset(port_reset), .port_enable(port_enable),
      .keyer_on(keyer_on), .bypass_on(bypass_on), .cc_in(cc_in), .cc_out(cc_out),
      .upstream_present(upstream_present), .src_regen(src_regen), .src_wire(src_wire),
      .src_serial(src_serial), .src_article(src_article), .store_act(store_act));
   remote_contacts contacts (.sys_clk(sys_clk), .gpi_n(gpi_n));

   initial begin
      sys_clk = 0;
      forever #25 sys_clk = ~sys_clk;
   end

   // Pulse counters, so a short pulse is never missed between reads
   always @(posedge sys_clk) begin
      for (int i = 0; i < 3; i++) if (port_reset[i] === 1'b1) rst_cnt[i]++;
      seen <= clr_seen ? '0 : (seen | store_act);
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Expected source selects {article, serial, wire, regen} for one mode
   function automatic logic [3:0] src_exp(input logic [2:0] m);
      case (m)
         3'd0: return 4'h1;
         3'd2: return 4'h2;
         3'd3, 3'd4: return 4'h4;
         3'd5: return 4'h8;
         default: return 4'h0;
      endcase
   endfunction

   // Expected indicator: block first, then presence, then mode letter
   function automatic logic [2:0] ind_exp(input logic [2:0] m, input logic p);
      if (m == 3'd1) return 3'd1;
      if (p) return 3'd2;
      case (m)
         3'd2: return 3'd6;
         3'd3: return 3'd3;
         3'd4: return 3'd4;
         3'd5: return 3'd5;
         default: return 3'd0;
      endcase
   endfunction

   task automatic cc_chk(input logic [6:0] b1, b2, eb1, eb2);
      @(posedge sys_clk) cc_in <= '{1'b1, b1, b2};
      @(posedge sys_clk) #1;
      `CHK("row shift", {1'b1, eb1, eb2}, cc_out)
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge sys_clk); n++; end while (pready !== 1'b1 && n < 50);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic settle();
      repeat (D + 8) @(posedge sys_clk);
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge sys_clk);
      n_fail++;
      finish_test();
   end

   initial begin
      seed = 32'd22;
      rstn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0; pwdata = '0;
      port_byte_rx = '0; cc_in = '0; clr_seen = 0; upstream_present = '0;
      rst_cnt = '{0, 0, 0};
      repeat (20) @(posedge sys_clk);
      rstn <= 1'b1;
      upstream_present <= N_STREAMS'(rnd());
      // Reset values of control, revisions, idle monitor, unmapped place
      apb(0, OFF_CTRL, 0); `CHK("ctrl reset", CTRL_RESET, q)
      apb(0, OFF_REV, 0); `CHK("revisions", {8'h00, RA, RB, RC}, q)
      apb(0, OFF_GPI_MON, 0); `CHK("idle monitor", 32'h0000_00FF, q)
      apb(1, 12'h100, 32'hFFFF_FFFF); apb(0, 12'h100, 0); `CHK("unmapped", 32'h0, q)
      apb(0, OFF_STATUS, 0); `CHK("idle status", 32'h0000_0004, q)
      `CHK("keyer idle", 1'b1, keyer_on)
      // Each port disable with contact bounce gives one reset
      for (int p = 0; p < 3; p++) begin
         contacts.set_line(2 * p, 1'b1, 3); settle();
         `CHK("port reset count", 1, rst_cnt[p])
         `CHK("port gated", 3'h7 & ~(3'h1 << p), port_enable)
         contacts.set_line(2 * p, 1'b0, 3); settle();
         `CHK("port back", 3'h7, port_enable)
      end
      // Random contact words seen on the monitor and the outputs
      for (int k = 0; k < 6; k++) begin
         v = (k == 0) ? 8'h00 : 8'(rnd());
         contacts.set_word(v); settle();
         apb(0, OFF_GPI_MON, 0); `CHK("monitor word", {24'h0, v}, q)
         `CHK("bypass", ~v[BIT_BYPASS_EN], bypass_on)
         `CHK("keyer master", v[BIT_KEYER_DIS], keyer_on)
      end
      contacts.set_word(8'hFF); settle();
      // Temporary mode holds the keyer off until a byte arrives
      apb(1, OFF_CTRL, 32'h1);
      contacts.set_line(BIT_KEYER_DIS, 1'b1, 0); settle();
      `CHK("temp off", 1'b0, keyer_on)
      contacts.set_line(BIT_KEYER_DIS, 1'b0, 0); settle();
      `CHK("temp held", 1'b0, keyer_on)
      @(posedge sys_clk) port_byte_rx <= 3'b010;
      @(posedge sys_clk) port_byte_rx <= 3'b000;
      repeat (3) @(posedge sys_clk);
      `CHK("temp release", 1'b1, keyer_on)
      apb(1, OFF_CTRL, 32'h0);
      // Text bytes pass untouched, shift contact closed or not
      for (int k = 0; k < 16; k++) begin
         if (k == 8) begin contacts.set_line(BIT_SHIFT_UP, 1'b1, 2); settle(); end
         v = 8'(rnd());
         @(posedge sys_clk) cc_in <= '{1'b1, 7'h20 | v[6:0], 7'h40 | v[7:1]};
         @(posedge sys_clk) #1;
         `CHK("text pass", {1'b1, 7'h20 | v[6:0], 7'h40 | v[7:1]}, cc_out)
      end
      // Rows 12 and 15 move to 1 and 4, row 11 stays, open contact passes
      cc_chk(7'h13, 7'h40, 7'h11, 7'h40);
      cc_chk(7'h14, 7'h60, 7'h12, 7'h60);
      cc_chk(7'h10, 7'h40, 7'h10, 7'h40);
      contacts.set_line(BIT_SHIFT_UP, 1'b0, 0); settle();
      cc_chk(7'h13, 7'h40, 7'h13, 7'h40);
      // Local actions: which stores each one touches
      ex = '{6'b100000, 6'b111110, 6'b001001};
      mk = '{6'b110000, 6'b111110, 6'b111011};
      for (int a = 0; a < 3; a++) begin
         @(posedge sys_clk) clr_seen <= 1'b1;
         @(posedge sys_clk) clr_seen <= 1'b0;
         apb(1, OFF_ACTION, 32'h1 << a);
         repeat (3) @(posedge sys_clk);
         `CHK("store action", ex[a], 6'(seen) & mk[a])
      end
      // Random stream modes, every mode code among them
      for (int k = 0; k < 4; k++) begin
         for (int s = 0; s < N_STREAMS; s++) md[3*s +: 3] = 3'((rnd() % 6 + s + k) % 6);
         apb(1, OFF_STREAM_MD, {5'h0, md}); @(posedge sys_clk) #1;
         for (int s = 0; s < N_STREAMS; s++)
            `CHK("stream src", src_exp(md[3*s +: 3]), {src_article[s], src_serial[s],
               src_wire[s], src_regen[s]})
         apb(0, OFF_STREAM_IN, 0);
         for (int s = 0; s < N_STREAMS; s++)
            `CHK("stream ind", ind_exp(md[3*s +: 3], upstream_present[s]), q[3*s +: 3])
      end
      finish_test();
   end
endmodule
